// >>> rtl/omc_pkg.sv
package omc_pkg;

  // ***************************************
  // operating modes, gray coded
  // ***************************************
  typedef enum logic [1:0] {
    OMC_RESET   = 2'h0,
    OMC_ACTIVE  = 2'h1,
    OMC_STANDBY = 2'h3,
    OMC_SLEEP   = 2'h2
  } omc_mode_t;

  // ***************************************
  // counts and reset values
  // ***************************************
  localparam logic [3:0] OMC_RST_HOLD_CYC = 4'h2;  // countdown loaded on reset; reset lasts one cycle more than this after release
  localparam logic       OMC_GUARD_RST    = 1'h0;  // write-guard after power-up

endpackage

// >>> rtl/omc_sync_pulse.sv
`timescale 1ns/1ps
// one-cycle delay of the port write event, lining it up with the state register
module omc_sync_pulse (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic trig,
  output logic      pulse
);

  // ***************************************
  // single register stage
  // ***************************************
  typedef struct packed {
    logic pulse;
  } omc_pulse_t;

  omc_pulse_t pl_q;
  omc_pulse_t pl_d;

  // next value is simply this cycle's event
  always_comb begin
    pl_d       = pl_q;
    pl_d.pulse = trig;
  end

  // no pulse may leak out of reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pl_q <= '0;
    end else begin
      pl_q <= pl_d;
    end
  end

  assign pulse = pl_q.pulse;

endmodule

// >>> rtl/omc_mode_ctrl.sv
`timescale 1ns/1ps
module omc_mode_ctrl
  import omc_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic resetPin,
  input  wire logic resetPinDriven,
  input  wire logic portaComboRst,
  input  wire logic otherSysRst,
  input  wire logic haltExec,
  input  wire logic sleepWrite,
  input  wire logic sleepWriteVal,
  input  wire logic guardWrite,
  input  wire logic guardWriteVal,
  input  wire logic irqPending,
  input  wire logic portWriteBcd,
  output logic      instrClkEn,
  output logic      periphClkEn,
  output logic      oscRun,
  output logic      cpuResetOut,
  output logic      sleepFlag,
  output logic      sleepGuard,
  output logic      resetStrobeOutput,
  output logic      resumeAfterHalt
);

  // ***************************************
  // state
  // ***************************************
  // hold counter keeps the core in reset a few cycles after every source drops
  typedef struct packed {
    omc_mode_t  mode;
    logic [3:0] holdCnt;
    logic       sleepFlag;
    logic       guard;
    logic       instrClkEn;
    logic       periphClkEn;
    logic       oscRun;
    logic       cpuReset;
    logic       resume;
    logic       strobe;
  } omc_state_t;

  omc_state_t st_q;
  omc_state_t st_d;
  logic       extRst;
  logic       anyRst;
  logic       wakeRst;
  logic       strobeEv;
  logic       strobePulse;

  // undriven pin reads low, standing in for the pull-down
  assign extRst   = resetPinDriven & resetPin;
  assign wakeRst  = extRst | portaComboRst;
  assign anyRst   = wakeRst | otherSysRst;
  assign strobeEv = portWriteBcd & (st_q.mode == OMC_ACTIVE);

  // oscillator and peripheral clocks share one decode
  function automatic logic clocksRun(input omc_mode_t m);
    return m != OMC_SLEEP;
  endfunction

  // ***************************************
  // next-state logic
  // ***************************************
  // one arm per mode; a reset request outranks every mode change, but a guard write in ACTIVE still lands
  always_comb begin
    st_d        = st_q;
    st_d.resume = 1'h0;
    case (st_q.mode)
      OMC_RESET: begin
        if (anyRst) begin
          st_d.holdCnt = OMC_RST_HOLD_CYC;
        end else if (st_q.holdCnt != 4'h0) begin
          st_d.holdCnt = st_q.holdCnt - 4'h1;
        end else begin
          st_d.mode = OMC_ACTIVE;
        end
      end
      OMC_ACTIVE: begin
        // guard must be set beforehand; same-cycle guard write does not count
        if (anyRst) begin
          st_d.mode    = OMC_RESET;
          st_d.holdCnt = OMC_RST_HOLD_CYC;
        end else if (sleepWrite && sleepWriteVal && st_q.guard) begin
          st_d.mode      = OMC_SLEEP;
          st_d.sleepFlag = 1'h1;
        end else if (haltExec) begin
          st_d.mode = OMC_STANDBY;
        end
        if (guardWrite) begin
          st_d.guard = guardWriteVal;
        end
      end
      OMC_STANDBY: begin
        if (anyRst) begin
          st_d.mode    = OMC_RESET;
          st_d.holdCnt = OMC_RST_HOLD_CYC;
        end else if (irqPending) begin
          st_d.mode   = OMC_ACTIVE;
          st_d.resume = 1'h1;
        end
      end
      OMC_SLEEP: begin
        // interrupts and internal resets cannot act with oscillator stopped
        if (wakeRst) begin
          st_d.mode      = OMC_RESET;
          st_d.holdCnt   = OMC_RST_HOLD_CYC;
          st_d.sleepFlag = 1'h0;
        end
      end
      default: begin
        st_d.mode = OMC_RESET;
      end
    endcase
    // clock gating follows the next mode; pins and registers are not touched
    st_d.instrClkEn  = (st_d.mode == OMC_ACTIVE);
    st_d.periphClkEn = clocksRun(st_d.mode);
    st_d.oscRun      = clocksRun(st_d.mode);
    st_d.cpuReset    = (st_d.mode == OMC_RESET);
    st_d.strobe      = st_d.cpuReset | strobePulse;
  end

  // ***************************************
  // state register
  // ***************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q             <= '0;
      st_q.mode        <= OMC_RESET;
      st_q.holdCnt     <= OMC_RST_HOLD_CYC;
      st_q.guard       <= OMC_GUARD_RST;
      st_q.periphClkEn <= 1'h1;
      st_q.oscRun      <= 1'h1;
      st_q.cpuReset    <= 1'h1;
      st_q.strobe      <= 1'h1;
    end else begin
      st_q <= st_d;
    end
  end

  // strobe event delayed one cycle to align with register outputs
  omc_sync_pulse u_strobe (
    .mclk  (mclk),
    .rst_b (rst_b),
    .trig  (strobeEv),
    .pulse (strobePulse)
  );

  // ***************************************
  // outputs
  // ***************************************
  // every output is a field of the state register
  assign instrClkEn        = st_q.instrClkEn;
  assign periphClkEn       = st_q.periphClkEn;
  assign oscRun            = st_q.oscRun;
  assign cpuResetOut       = st_q.cpuReset;
  assign sleepFlag         = st_q.sleepFlag;
  assign sleepGuard        = st_q.guard;
  assign resetStrobeOutput = st_q.strobe;
  assign resumeAfterHalt   = st_q.resume;

  // ***************************************
  // checks
  // ***************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // halt taken only when nothing of higher priority is asked
  sequence s_haltSeen;
    st_q.mode == OMC_ACTIVE && !anyRst && !sleepWrite && haltExec;
  endsequence

  // guarded sleep write with no reset in the same cycle
  sequence s_sleepSeen;
    st_q.mode == OMC_ACTIVE && !anyRst && sleepWrite && sleepWriteVal && st_q.guard;
  endsequence

  // enabled interrupt while halted and no reset pending
  sequence s_irqWake;
    st_q.mode == OMC_STANDBY && irqPending && !anyRst;
  endsequence

  // any reset source while halted
  sequence s_standbyRst;
    st_q.mode == OMC_STANDBY && anyRst;
  endsequence

  // port write accepted while the core runs
  sequence s_portWrite;
    st_q.mode == OMC_ACTIVE && portWriteBcd;
  endsequence

  a_halt_enters_standby: assert property (s_haltSeen |=> st_q.mode == OMC_STANDBY)
    else $error("halt did not enter standby");
  a_standby_keeps_periph: assert property (
    st_q.mode == OMC_STANDBY |-> periphClkEn && oscRun)
    else $error("standby stopped peripherals");
  a_standby_gates_instr: assert property (st_q.mode == OMC_STANDBY |-> !instrClkEn)
    else $error("instruction clock running in standby");
  a_standby_keeps_bits: assert property (
    st_q.mode == OMC_STANDBY |=> $stable(sleepGuard) && $stable(sleepFlag))
    else $error("standby changed held bits");
  a_standby_irq_wake: assert property (
    s_irqWake |=> st_q.mode == OMC_ACTIVE && resumeAfterHalt && instrClkEn)
    else $error("interrupt did not end standby");
  a_standby_reset_exit: assert property (
    s_standbyRst |=> st_q.mode == OMC_RESET && cpuResetOut && resetStrobeOutput)
    else $error("reset did not end standby");
  a_sleep_write_enters: assert property (
    s_sleepSeen |=> st_q.mode == OMC_SLEEP && sleepFlag && !periphClkEn)
    else $error("guarded sleep write did not enter sleep");
  a_guard_blocks_sleep: assert property (
    st_q.mode == OMC_ACTIVE && !st_q.guard |=> st_q.mode != OMC_SLEEP)
    else $error("sleep entered without guard");
  a_sleep_stops_osc: assert property (st_q.mode == OMC_SLEEP |-> !oscRun && sleepFlag)
    else $error("oscillator running in sleep");
  a_sleep_ignores_rest: assert property (
    st_q.mode == OMC_SLEEP && !wakeRst |=> st_q.mode == OMC_SLEEP)
    else $error("sleep left without pin reset");
  a_sleep_wake_flags: assert property (
    st_q.mode == OMC_SLEEP && wakeRst |=> !sleepFlag && sleepGuard && st_q.mode == OMC_RESET)
    else $error("wake did not clear sleep flag");
  a_combo_resets: assert property (
    st_q.mode == OMC_ACTIVE && portaComboRst |=> st_q.mode == OMC_RESET ##1 resetStrobeOutput)
    else $error("port A combination did not reset");
  a_strobe_in_reset: assert property (cpuResetOut |-> resetStrobeOutput)
    else $error("strobe low during reset");
  a_port_write_strobe: assert property (s_portWrite |-> ##2 resetStrobeOutput)
    else $error("port write gave no strobe");

endmodule

// >>> bench/omc_far_side.sv
`timescale 1ns/1ps
// ************
// reset pad and port A lines
// ************
module omc_far_side (
  input  wire logic       padLevel,
  input  wire logic       padDrive,
  input  wire logic [3:0] portA,
  output logic            resetPin,
  output logic            resetPinDriven,
  output logic            portaComboRst
);
  // pull-down wins whenever the outside lets go
  assign resetPin       = padDrive & padLevel;
  assign resetPinDriven = padDrive;
  // combination of lines 0 and 1; upper lines do not matter
  assign portaComboRst  = portA[0] & portA[1];
endmodule

// >>> bench/tb_operating_mode_control.sv
`timescale 1ns/1ps
module tb_operating_mode_control;
  import omc_pkg::*;
  logic       mclk, rst_b, padLevel, padDrive, otherSysRst, irqPending;
  logic       sleepWriteVal, guardWriteVal;
  logic [3:0] portA, pul;
  logic       resetPin, resetPinDriven, portaComboRst;
  logic       instrClkEn, periphClkEn, oscRun, cpuResetOut;
  logic       sleepFlag, sleepGuard, resetStrobeOutput, resumeAfterHalt;
  int         miscompares, checksDone, n;

  always #25 mclk = ~mclk;

  omc_far_side far_u (.padLevel(padLevel), .padDrive(padDrive), .portA(portA),
    .resetPin(resetPin), .resetPinDriven(resetPinDriven), .portaComboRst(portaComboRst));

  omc_mode_ctrl dut_u (.mclk(mclk), .rst_b(rst_b), .resetPin(resetPin),
    .resetPinDriven(resetPinDriven), .portaComboRst(portaComboRst),
    .otherSysRst(otherSysRst), .haltExec(pul[0]), .sleepWrite(pul[1]),
    .sleepWriteVal(sleepWriteVal), .guardWrite(pul[2]), .guardWriteVal(guardWriteVal),
    .irqPending(irqPending), .portWriteBcd(pul[3]), .instrClkEn(instrClkEn),
    .periphClkEn(periphClkEn), .oscRun(oscRun), .cpuResetOut(cpuResetOut),
    .sleepFlag(sleepFlag), .sleepGuard(sleepGuard),
    .resetStrobeOutput(resetStrobeOutput), .resumeAfterHalt(resumeAfterHalt));

  // ************
  // helpers
  // ************
  // inputs always move 5 ns after the edge, away from sampling
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #5;
  endtask

  task automatic chk(input string nm, input logic e, input logic g);
    checksDone++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s exp %b got %b", nm, e, g);
    end
  endtask

  task automatic mode(input logic ins, input logic osc, input logic rst);
    chk("instrClkEn", ins, instrClkEn);
    chk("oscRun", osc, oscRun);
    chk("cpuResetOut", rst, cpuResetOut);
  endtask

  // one-cycle request pulse
  task automatic fire(input logic [3:0] v);
    pul = v;
    step(1);
    pul = 4'h0;
  endtask

  task automatic summarize;
    if (miscompares == 0 && checksDone > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ************
  // watchdog and tests
  // ************
  initial begin
    #(4000 * 50);
    miscompares++;
    summarize();
  end

  initial begin
    {mclk, rst_b, padLevel, padDrive, otherSysRst, irqPending} = 6'h00;
    {sleepWriteVal, guardWriteVal, portA, pul} = 10'h000;
    void'($urandom(93594));
    repeat (20) @(posedge mclk);
    #5 rst_b = 1'h1;
    chk("strobe", 1'h1, resetStrobeOutput);
    chk("sleepGuard", 1'h0, sleepGuard);
    step(6);
    mode(1'h1, 1'h1, 1'h0);
    chk("strobe", 1'h0, resetStrobeOutput);
    // outside level high but pad left floating
    padLevel = 1'h1;
    step(3);
    mode(1'h1, 1'h1, 1'h0);
    padLevel = 1'h0;
    sleepWriteVal = 1'h1;
    fire(4'h2);
    mode(1'h1, 1'h1, 1'h0);
    // guard written alongside the sleep bit must not open it yet
    guardWriteVal = 1'h1;
    step(1);
    fire(4'h6);
    mode(1'h1, 1'h1, 1'h0);
    chk("sleepGuard", 1'h1, sleepGuard);
    step(1);
    fire(4'h2);
    mode(1'h0, 1'h0, 1'h0);
    chk("sleepFlag", 1'h1, sleepFlag);
    chk("periphClkEn", 1'h0, periphClkEn);
    // neither interrupt nor other sources may wake the sleeper
    {otherSysRst, irqPending} = 2'h3;
    step(3);
    mode(1'h0, 1'h0, 1'h0);
    {otherSysRst, irqPending, padDrive, padLevel} = 4'h3;
    step(1);
    chk("cpuResetOut", 1'h1, cpuResetOut);
    chk("strobe", 1'h1, resetStrobeOutput);
    chk("sleepFlag", 1'h0, sleepFlag);
    chk("sleepGuard", 1'h1, sleepGuard);
    {padDrive, padLevel} = 2'h0;
    step(6);
    // random standby lengths, each ended by an interrupt
    for (int i = 0; i < 6; i++) begin
      n = $urandom_range(1, 8);
      fire(4'h1);
      mode(1'h0, 1'h1, 1'h0);
      step(n);
      chk("periphClkEn", 1'h1, periphClkEn);
      chk("sleepGuard", 1'h1, sleepGuard);
      irqPending = 1'h1;
      step(1);
      irqPending = 1'h0;
      mode(1'h1, 1'h1, 1'h0);
      chk("resumeAfterHalt", 1'h1, resumeAfterHalt);
    end
    fire(4'h1);
    otherSysRst = 1'h1;
    step(1);
    otherSysRst = 1'h0;
    chk("cpuResetOut", 1'h1, cpuResetOut);
    step(6);
    portA = 4'($urandom) | 4'h3;
    step(1);
    portA = 4'h0;
    chk("cpuResetOut", 1'h1, cpuResetOut);
    step(6);
    // port write strobe lands two cycles after the write
    fire(4'h8);
    chk("strobe", 1'h0, resetStrobeOutput);
    step(1);
    chk("strobe", 1'h1, resetStrobeOutput);
    step(1);
    chk("strobe", 1'h0, resetStrobeOutput);
    summarize();
  end
endmodule
